// [jts_consts.vh]
/*
 * constants shared by the tap select and emulation line block.
 * assumes a 32-bit ahb-lite register bus with byte addresses.
 */
`ifndef JTS_CONSTS_VH
`define JTS_CONSTS_VH

// =====================================================================
// register map
`define JTS_ADDR_PULL_INHIBIT   32'h0000_1c18
`define JTS_ADDR_STATUS         32'h0000_1c1c
`define JTS_REG_W               16
`define JTS_PULL_INHIBIT_RST    16'h0000

// =====================================================================
// pull inhibit field positions (1 = resistor off)
`define JTS_PI_TRST_PD          0
`define JTS_PI_TAP_SELECT_EMULATOR_LINE_PU          1
`define JTS_PI_EMULATOR_EVENT_LINE_PU          2
`define JTS_PI_TDI_PU           3
`define JTS_PI_TDO_PU           4
`define JTS_PI_TMS_PU           5

// =====================================================================
// status field positions
`define JTS_ST_TEST_ACTIVE      0
`define JTS_ST_TAP_SEL          1
`define JTS_ST_TRST_LVL         2
`define JTS_ST_CAPTURED         3
`define JTS_ST_TDO_LVL          4

// =====================================================================
// tap select codes
`define JTS_SEL_BSCAN           1'b0
`define JTS_SEL_EMU             1'b1

// =====================================================================
// ahb-lite codes
`define JTS_HTRANS_NONSEQ_BIT   1
`define JTS_HSIZE_WORD          3'h2
`define JTS_HRESP_OKAY          1'b0

// =====================================================================
// synchroniser bit order and reset levels
`define JTS_SY_TRST             0
`define JTS_SY_TCK              1
`define JTS_SY_TMS              2
`define JTS_SY_TDI              3
`define JTS_SY_TAP_SELECT_EMULATOR_LINE             4
`define JTS_SY_EMULATOR_EVENT_LINE             5
`define JTS_SY_TDO              6
`define JTS_SY_W                7
`define JTS_SY_RST              7'h7c

`endif

// [jts_sync.v]
/*
 * two flip-flop level synchroniser, one per bit.
 * assumes inputs are asynchronous to clk; reset levels are constants.
 */
`timescale 1ns/1ps

module jts_sync #(
   parameter             W       = 1,
   parameter [W-1:0]     RST_VAL = {W{1'b0}}
) (
   // clock and reset
   input  wire           clk,
   input  wire           rst_n,
   // async in, sync out
   input  wire [W-1:0]   d_async,
   output wire [W-1:0]   q_sync
);

   genvar i;

   // =====================================================================
   // per bit chain
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg meta_ff;
         reg sync_ff;
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_ff <= RST_VAL[i];
               sync_ff <= RST_VAL[i];
            end else begin
               meta_ff <= d_async[i];
               sync_ff <= meta_ff;
            end
         end
         assign q_sync[i] = sync_ff;
      end
   endgenerate

endmodule

// [jts_top.v]
/*
 * test port select and emulation line logic with pull inhibit register.
 * assumes tap state machines and emulation logic sit outside; scan pins
 * arrive asynchronous to hclk and are sampled through two flip-flops.
 */
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "jts_consts.vh"

// What this block does
// - test reset high hands control to scan
// - test reset low: functional mode, scan ignored
// - capture select line on test reset rise
// - select 0 boundary tap, 1 emulation tap
// - select line becomes bidirectional emulator interrupt
// - second line is bidirectional emulator interrupt
// - pull resistors set by pull inhibit register
// - test reset pulldown enabled after reset
// - emulation line pullups enabled after reset
// - sample inputs on tck rise, tdo on fall
// - tdo driven only while scanning
module jts_top (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   input  wire [31:0] hwdata,
   output reg  [31:0] hrdata_ff,
   output reg         hreadyout_ff,
   output reg         hresp_ff,
   // scan pins
   input  wire        trst_pin,
   input  wire        tck_pin,
   input  wire        tms_pin,
   input  wire        tdi_pin,
   input  wire        tdo_in,
   output reg         tdo_out_ff,
   output reg         tdo_oe_ff,
   // emulation line pins
   input  wire        tap_select_emulator_line_in,
   output reg         tap_select_emulator_line_out_ff,
   output reg         tap_select_emulator_line_oe_ff,
   input  wire        emulator_event_line_in,
   output reg         emulator_event_line_out_ff,
   output reg         emulator_event_line_oe_ff,
   // pad pull controls, 1 = resistor off
   output reg  [15:0] pull_inhibit_ff,
   // boundary scan tap side
   output reg         bs_tap_rst_n_ff,
   output reg         bs_tck_rise_ff,
   output reg         bs_tck_fall_ff,
   output reg         bs_tms_ff,
   output reg         bs_tdi_ff,
   input  wire        bs_tdo,
   input  wire        bs_shifting,
   // emulation tap side
   output reg         em_tap_rst_n_ff,
   output reg         em_tck_rise_ff,
   output reg         em_tck_fall_ff,
   output reg         em_tms_ff,
   output reg         em_tdi_ff,
   input  wire        em_tdo,
   input  wire        em_shifting,
   // emulation logic line control
   input  wire        tap_select_emulator_line_drv_en,
   input  wire        tap_select_emulator_line_drv_val,
   input  wire        emulator_event_line_drv_en,
   input  wire        emulator_event_line_drv_val,
   output reg         tap_select_emulator_line_evt_in_ff,
   output reg         emulator_event_line_evt_in_ff,
   output reg         test_active_ff
);

   // =====================================================================
   // pin synchronisers
   wire [`JTS_SY_W-1:0] pins_async;
   wire [`JTS_SY_W-1:0] pins_s;

   assign pins_async = {tdo_in, emulator_event_line_in, tap_select_emulator_line_in,
                        tdi_pin, tms_pin, tck_pin, trst_pin};

   jts_sync #(
      .W       (`JTS_SY_W),
      .RST_VAL (`JTS_SY_RST)
   ) u_sync (
      .clk     (hclk),
      .rst_n   (hresetn),
      .d_async (pins_async),
      .q_sync  (pins_s)
   );

   wire trst_s = pins_s[`JTS_SY_TRST];
   wire tck_s  = pins_s[`JTS_SY_TCK];
   wire tms_s  = pins_s[`JTS_SY_TMS];
   wire tdi_s  = pins_s[`JTS_SY_TDI];
   wire tap_select_emulator_line_s = pins_s[`JTS_SY_TAP_SELECT_EMULATOR_LINE];
   wire emulator_event_line_s = pins_s[`JTS_SY_EMULATOR_EVENT_LINE];
   wire tdo_s  = pins_s[`JTS_SY_TDO];

   // =====================================================================
   // test reset edge and tap select capture
   reg  trst_d_ff;
   reg  tck_d_ff;
   reg  tap_sel_ff;
   reg  captured_ff;

   wire trst_rise = trst_s & ~trst_d_ff;
   wire test_on   = trst_s & captured_ff;
   wire tck_rise  = tck_s & ~tck_d_ff & test_on;
   wire tck_fall  = ~tck_s & tck_d_ff & test_on;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trst_d_ff   <= 1'b0;
         tck_d_ff    <= 1'b0;
         tap_sel_ff  <= `JTS_SEL_BSCAN;
         captured_ff <= 1'b0;
      end else begin
         trst_d_ff <= trst_s;
         tck_d_ff  <= tck_s;
         if (trst_rise) begin
            tap_sel_ff  <= tap_select_emulator_line_s;
            captured_ff <= 1'b1;
         end
      end
   end

   // =====================================================================
   // scan routing to the selected tap
   wire sel_bs = test_on & (tap_sel_ff == `JTS_SEL_BSCAN);
   wire sel_em = test_on & (tap_sel_ff == `JTS_SEL_EMU);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         test_active_ff  <= 1'b0;
         bs_tap_rst_n_ff <= 1'b0;
         em_tap_rst_n_ff <= 1'b0;
         bs_tck_rise_ff  <= 1'b0;
         bs_tck_fall_ff  <= 1'b0;
         em_tck_rise_ff  <= 1'b0;
         em_tck_fall_ff  <= 1'b0;
         bs_tms_ff       <= 1'b0;
         bs_tdi_ff       <= 1'b0;
         em_tms_ff       <= 1'b0;
         em_tdi_ff       <= 1'b0;
      end else begin
         test_active_ff  <= test_on;
         bs_tap_rst_n_ff <= sel_bs;
         em_tap_rst_n_ff <= sel_em;
         bs_tck_rise_ff  <= tck_rise & sel_bs;
         bs_tck_fall_ff  <= tck_fall & sel_bs;
         em_tck_rise_ff  <= tck_rise & sel_em;
         em_tck_fall_ff  <= tck_fall & sel_em;
         if (tck_rise & sel_bs) begin
            bs_tms_ff <= tms_s;
            bs_tdi_ff <= tdi_s;
         end
         if (tck_rise & sel_em) begin
            em_tms_ff <= tms_s;
            em_tdi_ff <= tdi_s;
         end
      end
   end

   // =====================================================================
   // test data out, changed on tck fall only; enable also cleared while test is off
   wire sel_tdo   = (tap_sel_ff == `JTS_SEL_EMU) ? em_tdo : bs_tdo;
   wire sel_shift = (tap_sel_ff == `JTS_SEL_EMU) ? em_shifting : bs_shifting;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tdo_out_ff <= 1'b0;
         tdo_oe_ff  <= 1'b0;
      end else if (!test_on) begin
         tdo_oe_ff  <= 1'b0;
      end else if (tck_fall) begin
         tdo_out_ff <= sel_tdo;
         tdo_oe_ff  <= sel_shift;
      end
   end

   // =====================================================================
   // emulation lines as bidirectional interrupts
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tap_select_emulator_line_out_ff <= 1'b0;
         tap_select_emulator_line_oe_ff  <= 1'b0;
         emulator_event_line_out_ff      <= 1'b0;
         emulator_event_line_oe_ff       <= 1'b0;
         tap_select_emulator_line_evt_in_ff                  <= 1'b1;
         emulator_event_line_evt_in_ff                  <= 1'b1;
      end else begin
         tap_select_emulator_line_out_ff <= tap_select_emulator_line_drv_val;
         tap_select_emulator_line_oe_ff  <= test_on & tap_select_emulator_line_drv_en;
         emulator_event_line_out_ff      <= emulator_event_line_drv_val;
         emulator_event_line_oe_ff       <= test_on & emulator_event_line_drv_en;
         tap_select_emulator_line_evt_in_ff                  <= test_on ? tap_select_emulator_line_s : 1'b1;
         emulator_event_line_evt_in_ff                  <= test_on ? emulator_event_line_s : 1'b1;
      end
   end

   // =====================================================================
   // ahb-lite address phase capture
   reg         wr_pend_ff;
   reg  [31:0] wr_addr_ff;

   wire        take    = hsel & hready & htrans[`JTS_HTRANS_NONSEQ_BIT];
   wire        take_wr = take & hwrite & (hsize == `JTS_HSIZE_WORD);
   wire        take_rd = take & ~hwrite;
   wire        wr_pi   = wr_pend_ff & (wr_addr_ff == `JTS_ADDR_PULL_INHIBIT);

   // =====================================================================
   // read mux, with forwarding of a write still in its data phase
   reg  [31:0] nxt_rdata;
   wire [15:0] pi_view = wr_pi ? hwdata[15:0] : pull_inhibit_ff;
   wire [15:0] status_val;

   assign status_val = {11'h000,
                        tdo_s,
                        captured_ff,
                        trst_s,
                        tap_sel_ff,
                        test_on};

   always @* begin
      nxt_rdata = 32'h0000_0000;
      if (haddr == `JTS_ADDR_PULL_INHIBIT) begin
         nxt_rdata = {16'h0000, pi_view};
      end else if (haddr == `JTS_ADDR_STATUS) begin
         nxt_rdata = {16'h0000, status_val};
      end else begin
         nxt_rdata = 32'h0000_0000;
      end
   end

   // =====================================================================
   // register file and bus answer
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff      <= 1'b0;
         wr_addr_ff      <= 32'h0000_0000;
         hrdata_ff       <= 32'h0000_0000;
         hreadyout_ff    <= 1'b1;
         hresp_ff        <= `JTS_HRESP_OKAY;
         pull_inhibit_ff <= `JTS_PULL_INHIBIT_RST;
      end else begin
         hreadyout_ff <= 1'b1;
         hresp_ff     <= `JTS_HRESP_OKAY;
         if (hready) begin
            wr_pend_ff <= take_wr;
            wr_addr_ff <= haddr;
         end
         if (take_rd) begin
            hrdata_ff <= nxt_rdata;
         end
         if (wr_pi) begin
            pull_inhibit_ff <= hwdata[15:0];
         end
      end
   end

endmodule

// [jts_checker.sv]
/*
 * checker for the tap select block: scan pulses, line drive, pull register.
 * assumes it is bound to jts_top and sees only its ports.
 */
`timescale 1ns/1ps
`include "jts_consts.vh"

// =====================================================================
// checker
module jts_checker (
   // clock, reset and bus
   input wire        hclk, hresetn, hsel, hwrite, hready,
   input wire [31:0] haddr, hwdata,
   input wire [1:0]  htrans,
   input wire [2:0]  hsize,
   input wire [15:0] pull_inhibit_ff,
   // scan side
   input wire        tdo_oe_ff, test_active_ff, tap_select_emulator_line_evt_in_ff, emulator_event_line_evt_in_ff,
   input wire        bs_tap_rst_n_ff, bs_tck_rise_ff, bs_tck_fall_ff,
   input wire        em_tap_rst_n_ff, em_tck_rise_ff, em_tck_fall_ff,
   // emulation lines
   input wire        tap_select_emulator_line_drv_en, tap_select_emulator_line_drv_val, emulator_event_line_drv_en, emulator_event_line_drv_val,
   input wire        tap_select_emulator_line_out_ff, tap_select_emulator_line_oe_ff,
   input wire        emulator_event_line_out_ff, emulator_event_line_oe_ff
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence wr_pi;
      hsel && hready && htrans[1] && hwrite && hsize == `JTS_HSIZE_WORD && haddr == `JTS_ADDR_PULL_INHIBIT;
   endsequence
   sequence quiet2;
      !test_active_ff ##1 !test_active_ff;
   endsequence
   sequence drv0;
      test_active_ff && tap_select_emulator_line_drv_en ##1 test_active_ff;
   endsequence
   sequence drv1;
      test_active_ff && emulator_event_line_drv_en ##1 test_active_ff;
   endsequence

   a_pull_write: assert property (wr_pi |=> ##1 pull_inhibit_ff == $past(hwdata[15:0]))
      else $error("pull register write lost");
   a_idle_quiet: assert property (quiet2 |-> !bs_tck_rise_ff && !em_tck_rise_ff && !tdo_oe_ff
      && !bs_tap_rst_n_ff && !em_tap_rst_n_ff) else $error("scan active outside test");
   a_idle_lines: assert property (quiet2 |-> !tap_select_emulator_line_oe_ff && !emulator_event_line_oe_ff
      && tap_select_emulator_line_evt_in_ff && emulator_event_line_evt_in_ff) else $error("lines active outside test");
   a_one_tap: assert property (!(bs_tap_rst_n_ff && em_tap_rst_n_ff))
      else $error("both taps out of reset");
   a_route_rise: assert property ((bs_tck_rise_ff || bs_tck_fall_ff) |-> !em_tck_rise_ff
      && !em_tck_fall_ff && !em_tap_rst_n_ff) else $error("pulse on both taps");
   a_rise_gap: assert property (bs_tck_rise_ff |=> !bs_tck_rise_ff [*6])
      else $error("rise pulses too close");
   a_tdo_fall: assert property ($rose(tdo_oe_ff) |-> bs_tck_fall_ff || em_tck_fall_ff)
      else $error("tdo enable off falling edge");
   a_tap_select_emulator_line_drive: assert property (drv0 |-> tap_select_emulator_line_oe_ff
      && tap_select_emulator_line_out_ff == $past(tap_select_emulator_line_drv_val)) else $error("select line drive wrong");
   a_emulator_event_line_drive: assert property (drv1 |-> emulator_event_line_oe_ff
      && emulator_event_line_out_ff == $past(emulator_event_line_drv_val)) else $error("event line drive wrong");
endmodule

// [jts_emu_model.sv]
/*
 * emulator model: test reset, scan clock frames, emulation line pads.
 * assumes pads resolve against the block's enables and pull controls.
 */
`timescale 1ns/1ps

// =====================================================================
// emulator
module jts_emu_model (
   // scan pins
   output logic      trst_pin, tck_pin, tms_pin, tdi_pin,
   // pad levels
   output wire       tdo_in, tap_select_emulator_line_in, emulator_event_line_in,
   // block drive and pulls
   input wire        tdo_out_ff, tdo_oe_ff, tap_select_emulator_line_out_ff, tap_select_emulator_line_oe_ff,
   input wire        emulator_event_line_out_ff, emulator_event_line_oe_ff,
   input wire [15:0] pull_inhibit_ff
);
   logic e0_drv = 0, e0_val = 0, e1_drv = 0, e1_val = 0;
   // released pads: pull level, or inverse of last drive with pull off
   assign tdo_in = tdo_oe_ff ? tdo_out_ff : pull_inhibit_ff[4] ? ~tdo_out_ff : 1'b1;
   assign tap_select_emulator_line_in = tap_select_emulator_line_oe_ff ? tap_select_emulator_line_out_ff :
      e0_drv ? e0_val : pull_inhibit_ff[1] ? ~tap_select_emulator_line_out_ff : 1'b1;
   assign emulator_event_line_in = emulator_event_line_oe_ff ? emulator_event_line_out_ff :
      e1_drv ? e1_val : pull_inhibit_ff[2] ? ~emulator_event_line_out_ff : 1'b1;
   initial begin
      trst_pin = 0;
      tck_pin = 0;
      tms_pin = 1;
      tdi_pin = 0;
   end
   task test_reset(input logic s);
      e0_drv = 1;
      e0_val = s;
      trst_pin = 0;
      #1613 trst_pin = 1;
      #1600 e0_drv = 0;
   endtask
   // clock stands low between frames; data changes after the fall
   task frames(input logic [15:0] v);
      #13;
      for (int i = 0; i < 8; i++) begin
         tms_pin = v[2*i];
         tdi_pin = v[2*i+1];
         #400 tck_pin = 1;
         #400 tck_pin = 0;
      end
   endtask
endmodule

// [tb.sv]
/*
 * testbench for jts_top: pull register, tap select capture, scan routing.
 * assumes jts_emu_model as the emulator and jts_checker bound below.
 */
`timescale 1ns/1ps
`include "jts_consts.vh"
`define CHK(n,e,s) begin n_compared++; if ((e) !== (s)) begin errors++; $display("Error %s expected %h seen %h", n, e, s); end end

// =====================================================================
// bench
module tb;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout_ff, hresp_ff;
   logic [31:0] haddr = 0, hwdata = 0, hrdata_ff, rd, v, pi_m;
   logic [1:0]  htrans = 0, e2, tq[$];
   logic [2:0]  hsize = 3'h2;
   logic        trst_pin, tck_pin, tms_pin, tdi_pin, tdo_in, tdo_out_ff, tdo_oe_ff, sh = 0;
   logic        tap_select_emulator_line_in, tap_select_emulator_line_out_ff, tap_select_emulator_line_oe_ff;
   logic        emulator_event_line_in, emulator_event_line_out_ff, emulator_event_line_oe_ff;
   logic [15:0] pull_inhibit_ff;
   logic        bs_tap_rst_n_ff, bs_tck_rise_ff, bs_tck_fall_ff, bs_tms_ff, bs_tdi_ff, bs_tdo = 0, bs_shifting = 0;
   logic        em_tap_rst_n_ff, em_tck_rise_ff, em_tck_fall_ff, em_tms_ff, em_tdi_ff, em_tdo = 0, em_shifting = 0;
   logic        tap_select_emulator_line_drv_en = 0, tap_select_emulator_line_drv_val = 0, emulator_event_line_drv_en = 0, emulator_event_line_drv_val = 0;
   logic        tap_select_emulator_line_evt_in_ff, emulator_event_line_evt_in_ff, test_active_ff;
   logic        pbt = 0, pet = 0;
   int          errors = 0, n_compared = 0, nbs = 0, nem = 0;
   integer      seed = 32'h51e1;

   always #50 hclk = ~hclk;
   assign hready = hreadyout_ff;
   jts_top jts_top_inst (.*);
   jts_emu_model emu (.*);

   always @(posedge tck_pin) tq.push_back({tms_pin, tdi_pin});
   always @(posedge hclk) begin
      bs_shifting <= sh;
      em_shifting <= sh;
      bs_tdo <= $random(seed);
      em_tdo <= $random(seed);
      pbt <= bs_tdo;
      pet <= em_tdo;
      if (bs_tck_fall_ff || em_tck_fall_ff) begin
         `CHK("tdo out", bs_tck_fall_ff ? pbt : pet, tdo_out_ff)
      end
      if (bs_tck_rise_ff || em_tck_rise_ff) begin
         nbs += bs_tck_rise_ff;
         nem += em_tck_rise_ff;
         e2 = tq.size() ? tq.pop_front() : 2'bxx;
         `CHK("scan sample", e2, bs_tck_rise_ff ? {bs_tms_ff, bs_tdi_ff} : {em_tms_ff, em_tdi_ff})
      end
   end

   task tally_and_finish;
      if (errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task wrdy;
      int k;
      k = 0;
      do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 64);
      if (k >= 64) begin errors++; tally_and_finish; end
   endtask
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1; htrans <= 2'b10; haddr <= a; hwrite <= w;
      wrdy;
      hsel <= 0; htrans <= 2'b00; hwdata <= d;
      wrdy;
      rd = hrdata_ff;
      `CHK("okay", 1'b0, hresp_ff)
   endtask
   task run(input logic s);
      nbs = 0;
      nem = 0;
      emu.frames($random(seed));
      repeat (8) @(posedge hclk);
   endtask

   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1;
      ahb(0, `JTS_ADDR_PULL_INHIBIT, 0);
      `CHK("pull reset", 3'b000, rd[2:0])
      repeat (3) begin
         v = $random(seed);
         pi_m = {16'h0, v[15:0]};
         ahb(1, `JTS_ADDR_PULL_INHIBIT, v);
         ahb(0, `JTS_ADDR_PULL_INHIBIT, 0);
         `CHK("pull rw", pi_m, rd)
         `CHK("pull pads", pi_m[15:0], pull_inhibit_ff)
      end
      ahb(1, `JTS_ADDR_PULL_INHIBIT, 0);
      ahb(0, 32'h1c20, 0);
      `CHK("unmapped", 32'h0, rd)
      ahb(0, `JTS_ADDR_STATUS, 0);
      `CHK("idle", 1'b0, rd[0])
      run(0);
      `CHK("ignored", 0, nbs + nem)
      for (int s = 0; s < 2; s++) begin
         emu.test_reset(s[0]);
         ahb(0, `JTS_ADDR_STATUS, 0);
         `CHK("capture", {s[0], 1'b1}, rd[1:0])
         `CHK("tap reset", {s[0], ~s[0]}, {em_tap_rst_n_ff, bs_tap_rst_n_ff})
         tq.delete();
         sh <= 1;
         run(1);
         `CHK("emu tap", s ? 8 : 0, nem)
         `CHK("bscan tap", s ? 0 : 8, nbs)
         `CHK("tdo on", 1'b1, tdo_oe_ff)
         sh <= 0;
         run(1);
         `CHK("tdo off", 1'b0, tdo_oe_ff)
         emu.e0_drv = 1;
         emu.e0_val = ~s[0];
         ahb(0, `JTS_ADDR_STATUS, 0);
         `CHK("held", s[0], rd[1])
         emu.e0_drv = 0;
         v = $random(seed);
         emu.e1_drv = 1;
         emu.e1_val = v[1];
         tap_select_emulator_line_drv_en <= 1;
         tap_select_emulator_line_drv_val <= v[0];
         repeat (6) @(posedge hclk);
         `CHK("select pad", v[0], tap_select_emulator_line_in)
         `CHK("select in", v[0], tap_select_emulator_line_evt_in_ff)
         `CHK("event in", v[1], emulator_event_line_evt_in_ff)
         emu.e1_drv = 0;
         tap_select_emulator_line_drv_en <= 0;
         emulator_event_line_drv_en <= 1;
         emulator_event_line_drv_val <= v[2];
         repeat (4) @(posedge hclk);
         `CHK("event pad", v[2], emulator_event_line_in)
         emulator_event_line_drv_en <= 0;
      end
      emu.trst_pin = 0;
      run(0);
      ahb(0, `JTS_ADDR_STATUS, 0);
      `CHK("test off", 1'b0, rd[0])
      `CHK("off ignored", 0, nbs + nem)
      tally_and_finish;
   end
endmodule

bind jts_top jts_checker jts_checker_inst (.*);
